/* hdl/ewp_host.sv */
/*
  Host controller for a write-protected parallel EEPROM: accepts read, write
  and unprotect commands, issues key sequences, page loads and status polling.
  Assumes the EEPROM pins are wired directly and the data bus is resolved outside.
*/
// Contract
// - Protected mode: key before the first write of each page
// - Three key writes precede the data
// - Enable key sequence always followed by data write
// - Six key writes clear protection
// - Key writes issued back to back
`timescale 1ns/1ps
module ewp_host #(
  parameter int BYTE_LOAD_CYC = ewp_pkg::BYTE_LOAD_CYC,   // Page byte window in cycles
  parameter int WRITE_CYCLE_CYC = ewp_pkg::WRITE_CYCLE_CYC, // Settle after disable
  parameter int POLL_LIMIT_CYC = ewp_pkg::POLL_LIMIT_CYC,   // Give up polling after this
  parameter int TMR_W = 24                                 // Timer width
) (
  input wire logic SYS_CLK,         // System clock, 100 MHz
  input wire logic RESETN,          // Synchronous reset, active low
  input wire logic PROTECT_EN,      // Use keyed writes
  input wire logic CMD_VALID,       // Command offered
  output logic CMD_READY,           // Command taken when both high
  input wire logic [1:0] CMD_OP,    // ewp_op_t code
  input wire logic [14:0] CMD_ADDR, // Byte address
  input wire logic [7:0] CMD_DATA,  // Write data
  input wire logic CMD_LAST,        // Last byte of the page
  output logic RSP_VALID,           // Command finished, one cycle
  output logic [7:0] RSP_DATA,      // Read data
  output logic RSP_ERR,             // Poll timed out
  output logic BUSY,                // Engine not idle
  output logic EE_CE_N,             // Chip select
  output logic EE_OE_N,             // Output gate
  output logic EE_WE_N,             // Write strobe
  output logic [14:0] EE_ADDR,      // Address pins
  output logic [7:0] EE_DQ_O,       // Data pins out
  output logic EE_DQ_OE,            // Data pins driven
  input wire logic [7:0] EE_DQ_I    // Data pins in
);
  if (TMR_W < $clog2(POLL_LIMIT_CYC + 1) || TMR_W < $clog2(WRITE_CYCLE_CYC + 1)
      || TMR_W < $clog2(BYTE_LOAD_CYC + 1) || BYTE_LOAD_CYC < 2) begin : g_chk
    $error("Timer too narrow for the requested counts");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_KEY = 3'h1, ST_DATA = 3'h3, ST_GAP = 3'h2,
    ST_POLL = 3'h6, ST_SETTLE = 3'h7, ST_RESP = 3'h5
  } ewp_st_t;

  ewp_pin_if pin ();
  ewp_st_t st_ff;
  logic [2:0] idx_ff;
  logic dis_ff, rd_ff, last_ff, first_ff, tog_ff, err_ff;
  logic [14:0] addr_ff;
  logic [7:0] data_ff, rsp_data_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic cmd_fire, key_last, poll_ok;

  ewp_pin_seq u_seq (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .pin(pin),
    .ce_n(EE_CE_N),
    .oe_n(EE_OE_N),
    .we_n(EE_WE_N),
    .addr(EE_ADDR),
    .dq_o(EE_DQ_O),
    .dq_oe(EE_DQ_OE),
    .dq_i(EE_DQ_I)
  );

  // Only writes may extend an open page; anything else waits for the page to close
  assign CMD_READY = (st_ff == ST_IDLE) ||
                     (st_ff == ST_GAP && !last_ff && CMD_OP == ewp_pkg::EWP_OP_WRITE);
  assign cmd_fire = CMD_VALID && CMD_READY;
  assign key_last = idx_ff == (dis_ff ? 3'(ewp_pkg::DISABLE_LEN - 1) : 3'(ewp_pkg::ENABLE_LEN - 1));
  // Done once the toggle bit has stopped and the poll bit shows true data
  assign poll_ok = !first_ff && (pin.rdata[ewp_pkg::TOGGLE_BIT] == tog_ff)
                   && (pin.rdata[ewp_pkg::POLL_BIT] == data_ff[ewp_pkg::POLL_BIT]);

  // Bus cycles requested while a key, data or poll step is pending
  assign pin.req = (st_ff == ST_KEY) || (st_ff == ST_DATA) || (st_ff == ST_POLL);
  assign pin.wr = (st_ff == ST_KEY) || (st_ff == ST_DATA && !rd_ff);
  assign pin.addr = (st_ff == ST_KEY) ? ewp_pkg::ewp_key_addr(idx_ff) : addr_ff;
  assign pin.wdata = (st_ff == ST_KEY) ? ewp_pkg::ewp_key_data(dis_ff, idx_ff) : data_ff;

  // Command engine
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      st_ff <= ST_IDLE;
      idx_ff <= 3'h0;
      dis_ff <= 1'b0;
      rd_ff <= 1'b0;
      last_ff <= 1'b0;
      addr_ff <= 15'h0;
      data_ff <= 8'h0;
    end else begin
      unique case (st_ff)
        ST_IDLE: if (cmd_fire) begin
          addr_ff <= CMD_ADDR;
          data_ff <= CMD_DATA;
          last_ff <= CMD_LAST;
          rd_ff <= CMD_OP == ewp_pkg::EWP_OP_READ;
          idx_ff <= 3'h0;
          dis_ff <= CMD_OP == ewp_pkg::EWP_OP_UNPROTECT;
          if (CMD_OP == ewp_pkg::EWP_OP_UNPROTECT) st_ff <= ST_KEY;
          else if (CMD_OP == ewp_pkg::EWP_OP_WRITE && PROTECT_EN) st_ff <= ST_KEY; // Re-key each page
          else st_ff <= ST_DATA;
        end
        ST_KEY: if (pin.done) begin
          idx_ff <= idx_ff + 3'h1;                  // Next key write follows at once
          if (key_last) st_ff <= dis_ff ? ST_SETTLE : ST_DATA;
        end
        // The last byte also waits out the byte window: polling before the part
        // starts programming could match the old cell and finish early
        ST_DATA: if (pin.done) begin
          if (rd_ff) st_ff <= ST_RESP;
          else st_ff <= ST_GAP;
        end
        ST_GAP: if (cmd_fire) begin
          addr_ff <= CMD_ADDR;
          data_ff <= CMD_DATA;
          last_ff <= CMD_LAST;
          st_ff <= ST_DATA;
        end else if (tmr_ff == TMR_W'(BYTE_LOAD_CYC - 1)) begin
          st_ff <= ST_POLL;                         // Window lapsed, part is programming
        end
        // Leave only at the end of a read, so no stale done reaches the next command
        ST_POLL: if (pin.done && (poll_ok || tmr_ff >= TMR_W'(POLL_LIMIT_CYC - 1))) st_ff <= ST_RESP;
        ST_SETTLE: if (tmr_ff == TMR_W'(WRITE_CYCLE_CYC - 1)) st_ff <= ST_RESP;
        ST_RESP: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // One timer serves the byte window, the poll limit and the disable settle
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) tmr_ff <= '0;
    else if (st_ff != ST_GAP && st_ff != ST_POLL && st_ff != ST_SETTLE) tmr_ff <= '0;
    // Restart on a new byte and again when the window closes, so the poll limit is its own
    else if (st_ff == ST_GAP && (cmd_fire || tmr_ff == TMR_W'(BYTE_LOAD_CYC - 1))) tmr_ff <= '0;
    else tmr_ff <= tmr_ff + TMR_W'(1);
  end

  // Poll history: previous toggle bit and whether a first read is still due
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      first_ff <= 1'b1;
      tog_ff <= 1'b0;
    end else if (st_ff != ST_POLL) begin
      first_ff <= 1'b1;
    end else if (pin.done) begin
      first_ff <= 1'b0;
      tog_ff <= pin.rdata[ewp_pkg::TOGGLE_BIT];
    end
  end

  // Answer fields
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rsp_data_ff <= 8'h0;
      err_ff <= 1'b0;
    end else if (st_ff == ST_DATA && pin.done && rd_ff) begin
      rsp_data_ff <= pin.rdata;
      err_ff <= 1'b0;
    end else if (st_ff == ST_POLL) begin
      err_ff <= !(pin.done && poll_ok);
    end else if (st_ff == ST_SETTLE) begin
      err_ff <= 1'b0;
    end
  end

  assign RSP_VALID = st_ff == ST_RESP;
  assign RSP_DATA = rsp_data_ff;
  assign RSP_ERR = err_ff;
  assign BUSY = st_ff != ST_IDLE;

  localparam int LOAD_LIM = BYTE_LOAD_CYC;

  sequence s_key_final;
    st_ff == ST_KEY && pin.done && key_last;
  endsequence
  sequence s_enable_key_final;
    s_key_final ##0 !dis_ff;
  endsequence

  a_key_to_data: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    s_enable_key_final |=> st_ff == ST_DATA && pin.wr && pin.addr == addr_ff) else $error("Key not followed by data");
  a_key_chain: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_ff == ST_KEY && pin.done && !key_last |=> st_ff == ST_KEY && pin.req) else $error("Key sequence interrupted");
  a_key_count: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    s_enable_key_final |-> idx_ff == 3'h2) else $error("Enable key length wrong");
  a_protect_rekey: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_ff == ST_IDLE && cmd_fire && PROTECT_EN && CMD_OP == ewp_pkg::EWP_OP_WRITE |=> st_ff == ST_KEY && idx_ff == 3'h0)
    else $error("Protected write without key");
  a_disable_settle: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    s_key_final ##0 dis_ff |-> idx_ff == 3'h5 ##1 st_ff == ST_SETTLE ##1 !pin.req) else $error("Disable path wrong");
  a_gap_bound: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_ff == ST_GAP |-> tmr_ff < TMR_W'(LOAD_LIM)) else $error("Byte window overrun");
  a_poll_finish: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_ff == ST_POLL && pin.done && poll_ok |=> RSP_VALID && !RSP_ERR) else $error("Poll completion lost");
  a_last_waits: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_ff == ST_DATA && pin.done && !rd_ff |=> st_ff == ST_GAP) else $error("Byte window skipped");
  a_gap_closed: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_ff == ST_GAP && last_ff |-> !CMD_READY) else $error("Page reopened after its last byte");
  a_poll_whole: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    st_ff == ST_POLL && !pin.done |=> st_ff == ST_POLL) else $error("Poll left inside a read");
endmodule : ewp_host

/* hdl/ewp_pin_seq.sv */
/*
  Pin sequencer: runs one write or read bus cycle on the EEPROM strobes.
  Assumes the engine holds req and the request fields steady until done.
*/
`timescale 1ns/1ps
module ewp_pin_seq (
  input wire logic clk,             // System clock
  input wire logic rst_n,           // Synchronous reset, active low
  ewp_pin_if.seq pin,               // Request from the engine
  output logic ce_n,                // Chip select, active low
  output logic oe_n,                // Output gate, active low
  output logic we_n,                // Write strobe, active low
  output logic [14:0] addr,         // Address pins
  output logic [7:0] dq_o,          // Data out
  output logic dq_oe,               // Data drive enable
  input wire logic [7:0] dq_i       // Data in from the pins
);
  typedef enum logic [1:0] {PS_IDLE = 2'h0, PS_SETUP = 2'h1, PS_STROBE = 2'h3, PS_HOLD = 2'h2} ewp_ps_t;
  ewp_ps_t st_ff;
  logic [4:0] cnt_ff;
  logic wr_ff, ce_n_ff, oe_n_ff, we_n_ff, dq_oe_ff;
  logic [14:0] addr_ff;
  logic [7:0] dq_o_ff, rdata_ff, dq_s1_ff, dq_s2_ff;
  logic [4:0] we_lo_ff;

  // Two stages before anyone looks at the pins
  always_ff @(posedge clk) begin
    dq_s1_ff <= dq_i;
    dq_s2_ff <= dq_s1_ff;
  end

  // Phase machine; strobes only move between phases
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= PS_IDLE;
      cnt_ff <= 5'h0;
      wr_ff <= 1'b0;
      ce_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      addr_ff <= 15'h0;
      dq_o_ff <= 8'h0;
      rdata_ff <= 8'h0;
    end else begin
      unique case (st_ff)
        PS_IDLE: if (pin.req) begin
          st_ff <= PS_SETUP;
          wr_ff <= pin.wr;
          addr_ff <= pin.addr;                     // Address loads on the same edge that chip select falls; the write strobe falls SETUP_CYC later
          dq_o_ff <= pin.wdata;
          dq_oe_ff <= pin.wr;
          ce_n_ff <= 1'b0;
          oe_n_ff <= pin.wr;                       // Gate stays high for a write
          cnt_ff <= 5'(ewp_pkg::SETUP_CYC - 1);
        end
        PS_SETUP: if (cnt_ff == 5'h0) begin
          st_ff <= PS_STROBE;
          we_n_ff <= !wr_ff;
          cnt_ff <= wr_ff ? 5'(ewp_pkg::WE_LOW_CYC - 1) : 5'(ewp_pkg::READ_CYC - 1);
        end else begin
          cnt_ff <= cnt_ff - 5'h1;
        end
        PS_STROBE: if (cnt_ff == 5'h0) begin
          st_ff <= PS_HOLD;
          we_n_ff <= 1'b1;                         // Data still driven at the rising edge
          oe_n_ff <= 1'b1;
          if (!wr_ff) rdata_ff <= dq_s2_ff;
          cnt_ff <= 5'(ewp_pkg::HOLD_CYC - 1);
        end else begin
          cnt_ff <= cnt_ff - 5'h1;
        end
        PS_HOLD: if (cnt_ff == 5'h0) begin
          st_ff <= PS_IDLE;
          ce_n_ff <= 1'b1;
          dq_oe_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 5'h1;
        end
      endcase
    end
  end

  // Helper: length of the current write strobe low time
  always_ff @(posedge clk) begin
    if (!rst_n) we_lo_ff <= 5'h0;
    else we_lo_ff <= we_n_ff ? 5'h0 : we_lo_ff + 5'h1;
  end

  assign pin.done = (st_ff == PS_HOLD) && (cnt_ff == 5'h0);
  assign pin.rdata = rdata_ff;
  assign ce_n = ce_n_ff;
  assign oe_n = oe_n_ff;
  assign we_n = we_n_ff;
  assign addr = addr_ff;
  assign dq_o = dq_o_ff;
  assign dq_oe = dq_oe_ff;

  localparam int WE_MIN = ewp_pkg::WE_LOW_CYC;

  a_we_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(we_n_ff) |-> we_lo_ff >= 5'(WE_MIN)) else $error("Write strobe shorter than minimum");
  a_strobe_combo: assert property (@(posedge clk) disable iff (!rst_n)
    !we_n_ff |-> !ce_n_ff && oe_n_ff && dq_oe_ff) else $error("Write strobe low with bad companions");
  a_addr_steady: assert property (@(posedge clk) disable iff (!rst_n)
    !ce_n_ff && $past(!ce_n_ff) |-> $stable(addr_ff)) else $error("Address moved inside a bus cycle");
  a_data_at_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(we_n_ff) |-> dq_oe_ff && $stable(dq_o_ff) ##1 !ce_n_ff) else $error("Data not held at strobe rise");
endmodule : ewp_pin_seq

/* include/ewp_pin_if.sv */
/*
  Request/answer carrier between the command engine and the pin sequencer.
  Assumes both ends share one clock; req is a level, done a one-cycle pulse.
*/
`timescale 1ns/1ps
interface ewp_pin_if;
  logic req;
  logic wr;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;

  modport engine (output req, output wr, output addr, output wdata, input done, input rdata);
  modport seq (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : ewp_pin_if

/* include/ewp_pkg.sv */
/*
  Shared constants for the host side that drives a byte-wide parallel EEPROM
  with write protection: pin timing, the command key table and the polling bits.
  Assumes a 100 MHz system clock; every cycle count below is derived from that rate.
*/
package ewp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_NS = 10;
  // Least times round up to whole cycles
  localparam int SETUP_NS = 30;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_NS = 100;     // Well above the 20 ns noise filter
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_NS = 30;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_NS = 250;       // Access time plus the two sync stages
  localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  // Longest time rounds down
  localparam int BYTE_LOAD_US = 100;
  localparam int BYTE_LOAD_CYC = BYTE_LOAD_US * 1000 / CLK_NS;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000000 / CLK_NS;
  localparam int POLL_LIMIT_MS = 10;
  localparam int POLL_LIMIT_CYC = POLL_LIMIT_MS * 1000000 / CLK_NS;
  localparam int PHASE_W = 5;
  // Status bits seen on the data bus while the part programs
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  // Command key table
  localparam int ENABLE_LEN = 3;
  localparam int DISABLE_LEN = 6;
  localparam int KEY_IDX_W = 3;
  localparam logic [14:0] KEY_ADDR_A = 15'h0123;
  localparam logic [14:0] KEY_ADDR_B = 15'h0456;
  localparam logic [7:0] KEY_DATA_1 = 8'h3c;
  localparam logic [7:0] KEY_DATA_2 = 8'hc3;
  localparam logic [7:0] KEY_DATA_EN = 8'h5a;
  localparam logic [7:0] KEY_DATA_PRE = 8'h69;
  localparam logic [7:0] KEY_DATA_DIS = 8'ha5;

  typedef enum logic [1:0] {
    EWP_OP_WRITE = 2'h0,
    EWP_OP_READ = 2'h1,
    EWP_OP_UNPROTECT = 2'h2
  } ewp_op_t;

  // Address of key step idx; the disable key repeats the opening pair
  function automatic logic [14:0] ewp_key_addr(input logic [2:0] idx);
    ewp_key_addr = (idx == 3'h1 || idx == 3'h4) ? KEY_ADDR_B : KEY_ADDR_A;
  endfunction : ewp_key_addr

  function automatic logic [7:0] ewp_key_data(input logic dis, input logic [2:0] idx);
    unique case (idx)
      3'h0, 3'h3: ewp_key_data = KEY_DATA_1;
      3'h1, 3'h4: ewp_key_data = KEY_DATA_2;
      3'h2: ewp_key_data = dis ? KEY_DATA_PRE : KEY_DATA_EN;
      default: ewp_key_data = KEY_DATA_DIS;
    endcase
  endfunction : ewp_key_data
endpackage : ewp_pkg

/* verif/ewp_mem_model.sv */
/*
  Behavioural model of the write-protected byte-wide EEPROM at the host's pins.
  Assumes the bench resolves the data bus; the model has no clock and no reset.
*/
`timescale 1ns/1ps
module ewp_mem_model #(
  parameter real LOAD_NS = 1000.0, // Byte load window, shortened
  parameter real PROG_NS = 3000.0  // Internal programming time, shortened
) (
  input wire logic ce_n,           // Chip select, active low
  input wire logic oe_n,           // Output gate, active low
  input wire logic we_n,           // Write strobe, active low
  input wire logic [14:0] addr,    // Address pins
  input wire logic [7:0] din,      // Data from the host
  output logic [7:0] dq            // Read data, scrambled when released
);
  logic [7:0] mem [0:32767];
  logic [14:0] pg_a [$];
  logic [7:0] pg_d [$];
  logic prot, keyed, busy, wr_on, tog, dis_pend, drv;
  logic [2:0] k;
  logic [14:0] wa, last_a;
  logic [7:0] last_d;
  realtime t_fall, t_last;
  int n_bad, n_short, n_abort, n_prog;

  // Nonvolatile state: never reset, only set up once
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
    prot = 1'b0; // Shipped unprotected
    {keyed, busy, wr_on, tog, dis_pend, drv} = 6'h00;
    k = 3'h0;
    dq = 8'h00;
    {n_bad, n_short, n_abort, n_prog} = {4{32'h0}};
  end

  // Address at the later falling edge; gate low inhibits the write
  always @(negedge we_n or negedge ce_n) begin
    #0.1;
    if (!we_n && !ce_n && !wr_on) begin
      if (!oe_n) n_bad++;
      else begin
        wa = addr;
        t_fall = $realtime;
        wr_on = 1'b1;
      end
    end
  end

  // Data at the earlier rising edge; glitches dropped
  // Supply is modelled as always good, so only busy or a pending disable blocks writes
  always @(posedge we_n or posedge ce_n) begin
    if (wr_on) begin
      wr_on = 1'b0;
      if ($realtime - t_fall < 20.0) n_short++;
      else if (!busy && !dis_pend) take(wa, din);
    end
  end

  // Unkeyed data is dropped while protected, so nothing programs
  task automatic put(input logic [14:0] a, input logic [7:0] d);
    if (prot && !keyed) return;
    if (pg_a.size() < 64) begin // One to sixty-four bytes
      pg_a.push_back(a);
      pg_d.push_back(d);
    end
    last_a = a;
    last_d = d;
    t_last = $realtime;
  endtask : put

  task automatic miss(input logic [14:0] a, input logic [7:0] d);
    n_abort++;
    k = 3'h0;
    put(a, d);
  endtask : miss

  // Key matcher: any mismatch abandons the sequence
  task automatic take(input logic [14:0] a, input logic [7:0] d);
    case (k)
      3'h0: if (a == ewp_pkg::KEY_ADDR_A && d == ewp_pkg::KEY_DATA_1) k = 3'h1; else put(a, d);
      3'h1: if (a == ewp_pkg::KEY_ADDR_B && d == ewp_pkg::KEY_DATA_2) k = 3'h2; else miss(a, d);
      3'h2: begin
        if (a == ewp_pkg::KEY_ADDR_A && d == ewp_pkg::KEY_DATA_EN) begin
          keyed = 1'b1;
          k = 3'h0;
        end else if (a == ewp_pkg::KEY_ADDR_A && d == ewp_pkg::KEY_DATA_PRE) k = 3'h3;
        else miss(a, d);
      end
      3'h3: if (a == ewp_pkg::KEY_ADDR_A && d == ewp_pkg::KEY_DATA_1) k = 3'h4; else miss(a, d);
      3'h4: if (a == ewp_pkg::KEY_ADDR_B && d == ewp_pkg::KEY_DATA_2) k = 3'h5; else miss(a, d);
      default: begin
        if (a == ewp_pkg::KEY_ADDR_A && d == ewp_pkg::KEY_DATA_DIS) dis_pend = 1'b1;
        else n_abort++;
        k = 3'h0;
      end
    endcase
  endtask : take

  // Programming starts when the load window lapses
  always begin
    #10;
    if (dis_pend) begin
      busy = 1'b1;
      prot = 1'b0; // Cleared, usable after one write cycle
      #(PROG_NS);
      dis_pend = 1'b0;
      busy = 1'b0;
    end else if (pg_a.size() > 0 && $realtime - t_last >= LOAD_NS) begin
      busy = 1'b1;
      if (keyed) prot = 1'b1;
      keyed = 1'b0; // Back to protected by itself
      n_prog++;
      while (pg_a.size() > 0) mem[pg_a.pop_front()] = pg_d.pop_front();
      #(PROG_NS);
      busy = 1'b0;
    end
  end

  // Reads: status bits while programming a read breaks a key
  always @(negedge oe_n) begin
    #1;
    if (!ce_n) begin
      if (k != 3'h0) begin
        n_abort++;
        k = 3'h0;
      end
      if (busy && addr == last_a) begin
        dq = {~last_d[7], tog, mem[addr][5:0]};
        tog = ~tog;
      end else dq = mem[addr];
      drv = 1'b1;
    end
  end

  // Released bus shows the inverse once; a second edge must not restore the old value
  always @(posedge oe_n or posedge ce_n) begin
    if (drv) begin
      dq = ~dq;
      drv = 1'b0;
    end
  end
endmodule : ewp_mem_model

/* verif/tb.sv */
/*
  Self-checking bench for the protected EEPROM host, with the device model.
  Assumes shortened timing parameters; inputs change on the falling clock edge.
*/
`timescale 1ns/1ps
module tb;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic PROTECT_EN = 1'b0;
  logic CMD_VALID = 1'b0;
  logic CMD_LAST = 1'b0;
  logic [1:0] CMD_OP = 2'h0;
  logic [14:0] CMD_ADDR = 15'h0000;
  logic [7:0] CMD_DATA = 8'h00;
  logic CMD_READY, RSP_VALID, RSP_ERR, BUSY, EE_CE_N, EE_OE_N, EE_WE_N, EE_DQ_OE;
  logic [7:0] RSP_DATA, EE_DQ_O, EE_DQ_I, mdl_dq;
  logic [14:0] EE_ADDR;
  int n_mismatch = 0;
  int checked = 0;

  always #5 SYS_CLK = ~SYS_CLK;
  // Host drive wins; otherwise the device or its scrambled release value
  assign EE_DQ_I = EE_DQ_OE ? EE_DQ_O : mdl_dq;

  ewp_host #(.BYTE_LOAD_CYC(200), .WRITE_CYCLE_CYC(400), .POLL_LIMIT_CYC(2000), .TMR_W(24)) dut (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .PROTECT_EN(PROTECT_EN), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA),
    .CMD_LAST(CMD_LAST), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_ERR(RSP_ERR),
    .BUSY(BUSY), .EE_CE_N(EE_CE_N), .EE_OE_N(EE_OE_N), .EE_WE_N(EE_WE_N), .EE_ADDR(EE_ADDR),
    .EE_DQ_O(EE_DQ_O), .EE_DQ_OE(EE_DQ_OE), .EE_DQ_I(EE_DQ_I));

  ewp_mem_model #(.LOAD_NS(1000.0), .PROG_NS(3000.0)) mdl (
    .ce_n(EE_CE_N), .oe_n(EE_OE_N), .we_n(EE_WE_N), .addr(EE_ADDR), .din(EE_DQ_O), .dq(mdl_dq));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Offer one command, hold it until taken, then withdraw it
  task automatic cmd(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d, input logic last);
    @(negedge SYS_CLK);
    CMD_VALID = 1'b1;
    CMD_OP = op;
    CMD_ADDR = a;
    CMD_DATA = d;
    CMD_LAST = last;
    #1; // Let the ready decode settle on the new opcode before looking at it
    while (CMD_READY !== 1'b1) @(negedge SYS_CLK);
    @(negedge SYS_CLK);
    CMD_VALID = 1'b0;
  endtask : cmd

  task automatic wait_rsp();
    do @(negedge SYS_CLK); while (RSP_VALID !== 1'b1);
  endtask : wait_rsp

  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    cmd(2'h1, a, 8'h00, 1'b0);
    wait_rsp();
    check(16'(RSP_DATA), 16'(exp));
  endtask : rd

  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic exp_err);
    cmd(2'h0, a, d, 1'b1);
    wait_rsp();
    check(16'(RSP_ERR), 16'(exp_err));
  endtask : wr

  // Idle pins during reset: all strobes high, bus released
  task automatic s_reset();
    check(16'({EE_CE_N, EE_OE_N, EE_WE_N, EE_DQ_OE, CMD_READY, BUSY}), 16'h003a);
  endtask : s_reset

  // Plain write accepted on a fresh part, polled to completion
  task automatic s_plain();
    PROTECT_EN = 1'b0;
    wr(15'h0010, 8'h35, 1'b0);
    rd(15'h0010, 8'h35);
    check(16'(mdl.prot), 16'h0000);
  endtask : s_plain

  // Keyed three-byte page: one programming pass, protection turns on
  task automatic s_keyed();
    PROTECT_EN = 1'b1;
    cmd(2'h0, 15'h0040, 8'h81, 1'b0);
    cmd(2'h0, 15'h0041, 8'h02, 1'b0);
    cmd(2'h0, 15'h0042, 8'hc4, 1'b1);
    wait_rsp();
    check(16'(RSP_ERR), 16'h0000);
    check(16'(mdl.n_prog), 16'h0002);
    check(16'(mdl.prot), 16'h0001);
    rd(15'h0041, 8'h02);
    rd(15'h0042, 8'hc4);
  endtask : s_keyed

  // Unkeyed write while protected is refused; polling times out
  task automatic s_reject();
    PROTECT_EN = 1'b0;
    wr(15'h0040, 8'h11, 1'b1);
    rd(15'h0040, 8'h81);
    check(16'(mdl.prot), 16'h0001);
  endtask : s_reject

  // Six-write disable, then plain writes work again
  task automatic s_unprot();
    cmd(2'h2, 15'h0000, 8'h00, 1'b0);
    wait_rsp();
    check(16'(mdl.prot), 16'h0000);
    wr(15'h0040, 8'h11, 1'b0);
    rd(15'h0040, 8'h11);
  endtask : s_unprot

  // Pin discipline seen by the device over the whole run
  task automatic s_pins();
    check(16'(mdl.n_bad), 16'h0000);
    check(16'(mdl.n_short), 16'h0000);
    check(16'(mdl.n_abort), 16'h0000);
  endtask : s_pins

  // Main sequence; reset held for eight cycles
  initial begin
    repeat (8) @(negedge SYS_CLK);
    s_reset();
    RESETN = 1'b1;
    s_plain();
    s_keyed();
    s_reject();
    s_unprot();
    s_pins();
    final_report();
  end

  // Watchdog: the run needs about 5000 cycles, so 30000 means a hang
  initial begin
    #300000;
    n_mismatch++;
    final_report();
  end
endmodule : tb
